// ### hdl/pwop_regs.svh
`ifndef PWOP_REGS_SVH
`define PWOP_REGS_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define PWOP_STAMP_CFG 8'hac
`define PWOP_STAMP_A   8'hb0
`define PWOP_STAMP_B   8'hb4
`define PWOP_GEN_CFG   8'hb8
`define PWOP_FORCE     8'hbc
`define PWOP_ACT_A     8'hc0
`define PWOP_ACT_B     8'hc4
// ----------------------------------------
// Field positions
// ----------------------------------------
`define PWOP_SA_MOM    3:0
`define PWOP_SB_MOM    7:4
`define PWOP_SA_PEND   8
`define PWOP_SB_PEND   9
`define PWOP_CFG_MOM   3:0
`define PWOP_T0_SEL    6:4
`define PWOP_T1_SEL    9:7
`define PWOP_HOLD_MOM  5:0
`define PWOP_A_HOLD    7:6
`define PWOP_B_HOLD    9:8
`define PWOP_A_TRIG    10
`define PWOP_A_ONE     12:11
`define PWOP_B_TRIG    13
`define PWOP_B_ONE     15:14
`define PWOP_ACT_BITS  23:0
`define PWOP_DOWN_BASE 12
// ----------------------------------------
// Reset values
// ----------------------------------------
`define PWOP_RST_WORD  32'h0000_0000
`define PWOP_RST_BIT   1'b0
`endif

// ### hdl/pwop_pkg.sv
package pwop_pkg;
  // Action and force level codes.
  typedef enum logic [1:0] {ACT_KEEP, ACT_LOW, ACT_HIGH, ACT_TOGGLE} pwop_act_type;
  // Extra event source codes; codes above none also select nothing.
  typedef enum logic [2:0] {SRC_F0, SRC_F1, SRC_F2, SRC_SYNC, SRC_NONE} pwop_src_type;
endpackage

// ### hdl/pwop_shadow.sv
`timescale 1ns/1ps
`include "pwop_regs.svh"
// Shadow and active copy pair with a selectable transfer moment.
module pwop_shadow #(
  parameter int W  = 16,
  parameter int MW = 4
) (
  input  wire logic          clk_sys,
  input  wire logic          reset,
  input  wire logic          wr,
  input  wire logic [W-1:0]  wdata,
  input  wire logic [MW-1:0] moment,
  input  wire logic [MW-2:0] moment_evt,
  output logic      [W-1:0]  shadow,
  output logic      [W-1:0]  active,
  output logic               pending
);
  import pwop_pkg::*;
  logic xfer;  // Copy shadow to active this cycle.
  // Zero copies at once, the top bit blocks, other bits wait for their event.
  assign xfer = pending & ~moment[MW-1]
              & ((moment[MW-2:0] == '0) | (|(moment[MW-2:0] & moment_evt)));
  // Shadow copy follows software writes.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      shadow <= '0;
    end else if (wr) begin
      shadow <= wdata;
    end
  end
  // Active copy takes the shadow at the first selected moment.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      active <= '0;
    end else if (xfer) begin
      active <= shadow;
    end
  end
  // A write wins over a transfer in the same cycle, so no value is lost.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pending <= `PWOP_RST_BIT;
    end else begin
      pending <= wr | (pending & ~xfer);
    end
  end
  AST_SHD_BLOCK: assert property (@(posedge clk_sys) disable iff (reset)
    (pending && moment[MW-1] && !wr) |=> (pending && $stable(active)))
    else $error("Blocked transfer changed the active copy.");
endmodule // pwop_shadow

// ### hdl/pwop_action.sv
`timescale 1ns/1ps
`include "pwop_regs.svh"
// Action logic for one output: event actions, one-off force and hold force.
module pwop_action (
  input  wire logic                  clk_sys,
  input  wire logic                  reset,
  input  wire logic                  dir_up,
  input  wire logic [5:0]            events,
  input  wire logic [23:0]           actions,
  input  wire pwop_pkg::pwop_act_type hold_level,
  input  wire logic                  oneoff,
  input  wire pwop_pkg::pwop_act_type oneoff_level,
  output logic                       out
);
  import pwop_pkg::*;
  pwop_act_type code;      // Winning event action.
  logic         next_out;  // Next output level.
  // Later events win: t1 over t0 over compare B, A, period, zero.
  always_comb begin
    code = ACT_KEEP;
    for (int i = 0; i < 6; i++) begin
      if (events[i]) begin
        code = pwop_act_type'(dir_up ? actions[2*i +: 2]
                                     : actions[`PWOP_DOWN_BASE + 2*i +: 2]);
      end
    end
  end
  // Apply the action, then one-off force, then hold force on top.
  always_comb begin
    case (code)
      ACT_LOW:    next_out = 1'b0;
      ACT_HIGH:   next_out = 1'b1;
      ACT_TOGGLE: next_out = ~out;
      default:    next_out = out;
    endcase
    if (oneoff && oneoff_level == ACT_LOW) begin
      next_out = 1'b0;
    end else if (oneoff && oneoff_level == ACT_HIGH) begin
      next_out = 1'b1;
    end
    if (hold_level == ACT_LOW) begin
      next_out = 1'b0;
    end else if (hold_level == ACT_HIGH) begin
      next_out = 1'b1;
    end
  end
  // Output register.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      out <= `PWOP_RST_BIT;
    end else begin
      out <= next_out;
    end
  end
  AST_ACT_TOGGLE: assert property (@(posedge clk_sys) disable iff (reset)
    (code == ACT_TOGGLE && !oneoff && hold_level inside {ACT_KEEP, ACT_TOGGLE})
    |=> (out != $past(out)))
    else $error("Toggle action did not invert the output.");
  AST_ACT_HOLD: assert property (@(posedge clk_sys) disable iff (reset)
    (hold_level == ACT_HIGH) |=> out)
    else $error("Hold high did not override the output.");
endmodule // pwop_action

// ### hdl/pwop_top.sv
`timescale 1ns/1ps
`include "pwop_regs.svh"
// ----------------------------------------
// PWM operator action logic
// ----------------------------------------
// Operation
// - Pending flag set on write, cleared on copy
// - Stamp copy: zero now, zero/period/sync, block
// - Extra event source: faults, sync, none
// - Action copy: zero now, zero/period/sync, block
// - One-off force level: low, high, else off
// - Inverting trigger bit fires one force
// - Hold force level: low, high, else off
// - Hold copy: zero, period, A, B, sync, block
// - Timer equal active stamp raises compare event
// - Action codes: keep, low, high, toggle
// - Output A down-count actions per event
// - Output A up-count actions per event
// - Output B own up and down actions
module pwop_top #(
  parameter int TW = 16
) (
  input  wire logic          clk_sys,
  input  wire logic          reset,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [7:0]    paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire logic [TW-1:0] timer_value,
  input  wire logic          timer_step,
  input  wire logic          timer_dir_up,
  input  wire logic          timer_zero_event,
  input  wire logic          timer_period_event,
  input  wire logic          sync_event,
  input  wire logic [2:0]    fault_event,
  output logic               output_a,
  output logic               output_b
);
  import pwop_pkg::*;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  logic        hit;          // Address maps to a register.
  logic        wr_en;        // Write takes effect this edge.
  logic        wr_stamp_a;   // Write to stamp A shadow.
  logic        wr_stamp_b;   // Write to stamp B shadow.
  logic        wr_act_a;     // Write to output A actions.
  logic        wr_act_b;     // Write to output B actions.
  logic [31:0] rd_mux;       // Read value before the data flop.

  // Register contents held here.
  logic [31:0] stamp_update_config;     // Stamp transfer moments.
  logic [31:0] generator_config;        // Moments and sources.
  logic [31:0] software_force_control;  // Force settings.

  // Shadow and active copies.
  logic [TW-1:0] stamp_a_shadow;  // Stamp A as written.
  logic [TW-1:0] stamp_b_shadow;  // Stamp B as written.
  logic [TW-1:0] stamp_a_active;  // Stamp A in use.
  logic [TW-1:0] stamp_b_active;  // Stamp B in use.
  logic          stamp_a_pending; // Stamp A awaits its copy.
  logic          stamp_b_pending; // Stamp B awaits its copy.
  logic [23:0]   act_a_shadow;    // Output A actions as written.
  logic [23:0]   act_b_shadow;    // Output B actions as written.
  logic [23:0]   act_a_active;    // Output A actions in use.
  logic [23:0]   act_b_active;    // Output B actions in use.
  logic          act_a_pending;   // Output A actions await copy.
  logic          act_b_pending;   // Output B actions await copy.
  logic [3:0]    hold_shadow;     // Hold levels as written.
  logic [3:0]    hold_active;     // Hold levels in use.

  // ----------------------------------------
  // Events
  // ----------------------------------------
  logic compare_a_event;   // Timer equals active stamp A.
  logic compare_b_event;   // Timer equals active stamp B.
  logic extra_event_zero;  // First extra event.
  logic extra_event_one;   // Second extra event.
  logic trig_a;            // Stored one-off trigger for A.
  logic trig_b;            // Stored one-off trigger for B.
  logic oneoff_a;          // One-off force pulse for A.
  logic oneoff_b;          // One-off force pulse for B.
  logic [5:0] events;      // Events in priority order.

  // ----------------------------------------
  // APB slave
  // ----------------------------------------

  // The slave never waits; unmapped addresses answer with an error.
  assign hit = (paddr == `PWOP_STAMP_CFG) || (paddr == `PWOP_STAMP_A)
            || (paddr == `PWOP_STAMP_B) || (paddr == `PWOP_GEN_CFG)
            || (paddr == `PWOP_FORCE) || (paddr == `PWOP_ACT_A)
            || (paddr == `PWOP_ACT_B);
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit;
  assign wr_en   = psel & penable & pwrite & hit;

  // Strobes into the shadow copies.
  assign wr_stamp_a = wr_en & (paddr == `PWOP_STAMP_A);
  assign wr_stamp_b = wr_en & (paddr == `PWOP_STAMP_B);
  assign wr_act_a   = wr_en & (paddr == `PWOP_ACT_A);
  assign wr_act_b   = wr_en & (paddr == `PWOP_ACT_B);

  // Read mux; stamp pending flags are read only and merged in here.
  always_comb begin
    rd_mux = `PWOP_RST_WORD;
    case (paddr)
      `PWOP_STAMP_CFG: begin
        rd_mux = stamp_update_config;
        rd_mux[`PWOP_SA_PEND] = stamp_a_pending;
        rd_mux[`PWOP_SB_PEND] = stamp_b_pending;
      end
      `PWOP_STAMP_A: rd_mux[TW-1:0] = stamp_a_shadow;
      `PWOP_STAMP_B: rd_mux[TW-1:0] = stamp_b_shadow;
      `PWOP_GEN_CFG: rd_mux = generator_config;
      `PWOP_FORCE:   rd_mux = software_force_control;
      `PWOP_ACT_A:   rd_mux[`PWOP_ACT_BITS] = act_a_shadow;
      `PWOP_ACT_B:   rd_mux[`PWOP_ACT_BITS] = act_b_shadow;
      default:       rd_mux = `PWOP_RST_WORD;
    endcase
  end

  // Read data are caught in the setup cycle and shown in the access cycle.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      prdata <= `PWOP_RST_WORD;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_mux;
    end
  end

  // Stamp configuration keeps only the two moment fields.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      stamp_update_config <= `PWOP_RST_WORD;
    end else if (wr_en && paddr == `PWOP_STAMP_CFG) begin
      stamp_update_config <= `PWOP_RST_WORD;
      stamp_update_config[`PWOP_SA_MOM] <= pwdata[`PWOP_SA_MOM];
      stamp_update_config[`PWOP_SB_MOM] <= pwdata[`PWOP_SB_MOM];
    end
  end

  // Generator configuration; source fields act at once.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      generator_config <= `PWOP_RST_WORD;
    end else if (wr_en && paddr == `PWOP_GEN_CFG) begin
      generator_config <= `PWOP_RST_WORD;
      generator_config[`PWOP_CFG_MOM] <= pwdata[`PWOP_CFG_MOM];
      generator_config[`PWOP_T0_SEL]  <= pwdata[`PWOP_T0_SEL];
      generator_config[`PWOP_T1_SEL]  <= pwdata[`PWOP_T1_SEL];
    end
  end

  // Force control; hold levels reach the outputs via their shadow.
  // Trigger bits are not stored here, so they always read back as zero.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      software_force_control <= `PWOP_RST_WORD;
    end else if (wr_en && paddr == `PWOP_FORCE) begin
      software_force_control <= `PWOP_RST_WORD;
      software_force_control[`PWOP_A_HOLD]   <= pwdata[`PWOP_A_HOLD];
      software_force_control[`PWOP_B_HOLD]   <= pwdata[`PWOP_B_HOLD];
      software_force_control[`PWOP_A_ONE]    <= pwdata[`PWOP_A_ONE];
      software_force_control[`PWOP_B_ONE]    <= pwdata[`PWOP_B_ONE];
      software_force_control[`PWOP_HOLD_MOM] <= pwdata[`PWOP_HOLD_MOM];
    end
  end

  // ----------------------------------------
  // One-off force triggers
  // ----------------------------------------

  // Only a change of the trigger bit fires; its value means nothing.
  assign oneoff_a = wr_en && paddr == `PWOP_FORCE
                  && (pwdata[`PWOP_A_TRIG] != trig_a);
  assign oneoff_b = wr_en && paddr == `PWOP_FORCE
                  && (pwdata[`PWOP_B_TRIG] != trig_b);

  // Stored trigger bits, compared against each new write.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      trig_a <= `PWOP_RST_BIT;
      trig_b <= `PWOP_RST_BIT;
    end else if (wr_en && paddr == `PWOP_FORCE) begin
      trig_a <= pwdata[`PWOP_A_TRIG];
      trig_b <= pwdata[`PWOP_B_TRIG];
    end
  end

  // ----------------------------------------
  // Event generation
  // ----------------------------------------

  // Compare events fire on a timer step that lands on the active stamp.
  assign compare_a_event = timer_step & (timer_value == stamp_a_active);
  assign compare_b_event = timer_step & (timer_value == stamp_b_active);

  // Source selection for the extra events; none and unused codes stay low.
  function automatic logic pick_source(input logic [2:0] sel,
                                       input logic [2:0] fault,
                                       input logic       sync);
    case (pwop_src_type'(sel))
      SRC_F0:   pick_source = fault[0];
      SRC_F1:   pick_source = fault[1];
      SRC_F2:   pick_source = fault[2];
      SRC_SYNC: pick_source = sync;
      default:  pick_source = 1'b0;
    endcase
  endfunction

  assign extra_event_zero = pick_source(generator_config[`PWOP_T0_SEL], fault_event, sync_event);
  assign extra_event_one  = pick_source(generator_config[`PWOP_T1_SEL], fault_event, sync_event);

  // Events from lowest to highest priority.
  assign events = {extra_event_one, extra_event_zero, compare_b_event,
                   compare_a_event, timer_period_event, timer_zero_event};

  // ----------------------------------------
  // Shadow copies
  // ----------------------------------------

  // Stamp A: zero, period and sync moments.
  pwop_shadow #(.W(TW), .MW(4)) u_stamp_a (
    .clk_sys    (clk_sys),
    .reset      (reset),
    .wr         (wr_stamp_a),
    .wdata      (pwdata[TW-1:0]),
    .moment     (stamp_update_config[`PWOP_SA_MOM]),
    .moment_evt ({sync_event, timer_period_event, timer_zero_event}),
    .shadow     (stamp_a_shadow),
    .active     (stamp_a_active),
    .pending    (stamp_a_pending)
  );

  // Stamp B: same moments, own field.
  pwop_shadow #(.W(TW), .MW(4)) u_stamp_b (
    .clk_sys    (clk_sys),
    .reset      (reset),
    .wr         (wr_stamp_b),
    .wdata      (pwdata[TW-1:0]),
    .moment     (stamp_update_config[`PWOP_SB_MOM]),
    .moment_evt ({sync_event, timer_period_event, timer_zero_event}),
    .shadow     (stamp_b_shadow),
    .active     (stamp_b_active),
    .pending    (stamp_b_pending)
  );

  // Output A actions follow the generator configuration moment.
  pwop_shadow #(.W(24), .MW(4)) u_act_a (
    .clk_sys    (clk_sys),
    .reset      (reset),
    .wr         (wr_act_a),
    .wdata      (pwdata[`PWOP_ACT_BITS]),
    .moment     (generator_config[`PWOP_CFG_MOM]),
    .moment_evt ({sync_event, timer_period_event, timer_zero_event}),
    .shadow     (act_a_shadow),
    .active     (act_a_active),
    .pending    (act_a_pending)
  );

  // Output B actions follow the same moment.
  pwop_shadow #(.W(24), .MW(4)) u_act_b (
    .clk_sys    (clk_sys),
    .reset      (reset),
    .wr         (wr_act_b),
    .wdata      (pwdata[`PWOP_ACT_BITS]),
    .moment     (generator_config[`PWOP_CFG_MOM]),
    .moment_evt ({sync_event, timer_period_event, timer_zero_event}),
    .shadow     (act_b_shadow),
    .active     (act_b_active),
    .pending    (act_b_pending)
  );

  // Hold levels: zero, period, compare A, compare B and sync moments.
  pwop_shadow #(.W(4), .MW(6)) u_hold (
    .clk_sys    (clk_sys),
    .reset      (reset),
    .wr         (wr_en && paddr == `PWOP_FORCE),
    .wdata      ({pwdata[`PWOP_B_HOLD], pwdata[`PWOP_A_HOLD]}),
    .moment     (software_force_control[`PWOP_HOLD_MOM]),
    .moment_evt ({sync_event, compare_b_event, compare_a_event,
                  timer_period_event, timer_zero_event}),
    .shadow     (hold_shadow),
    .active     (hold_active),
    .pending    ()
  );

  // ----------------------------------------
  // Output action units
  // ----------------------------------------

  // Output A: up set in the low half, down set in the high half.
  pwop_action u_out_a (
    .clk_sys      (clk_sys),
    .reset        (reset),
    .dir_up       (timer_dir_up),
    .events       (events),
    .actions      (act_a_active),
    .hold_level   (pwop_act_type'(hold_active[1:0])),
    .oneoff       (oneoff_a),
    .oneoff_level (pwop_act_type'(pwdata[`PWOP_A_ONE])),
    .out          (output_a)
  );

  // Output B: its own fields.
  pwop_action u_out_b (
    .clk_sys      (clk_sys),
    .reset        (reset),
    .dir_up       (timer_dir_up),
    .events       (events),
    .actions      (act_b_active),
    .hold_level   (pwop_act_type'(hold_active[3:2])),
    .oneoff       (oneoff_b),
    .oneoff_level (pwop_act_type'(pwdata[`PWOP_B_ONE])),
    .out          (output_b)
  );

  // ----------------------------------------
  // Assertions
  // ----------------------------------------

  // A completed write to stamp A.
  sequence seq_stamp_a_write;
    psel && penable && pwrite && paddr == `PWOP_STAMP_A;
  endsequence

  // Stamp A pending with no further write.
  sequence seq_stamp_a_idle;
    stamp_a_pending && !wr_stamp_a;
  endsequence

  AST_PEND_SET: assert property (@(posedge clk_sys) disable iff (reset)
    seq_stamp_a_write |=> stamp_a_pending)
    else $error("Pending flag not set after stamp write.");

  AST_IMM_COPY: assert property (@(posedge clk_sys) disable iff (reset)
    (seq_stamp_a_idle and stamp_update_config[`PWOP_SA_MOM] == 4'h0)
    |=> (!stamp_a_pending && stamp_a_active == $past(stamp_a_shadow)))
    else $error("Immediate stamp copy did not happen.");

  AST_ZERO_COPY: assert property (@(posedge clk_sys) disable iff (reset)
    (seq_stamp_a_idle and stamp_update_config[`PWOP_SA_MOM] == 4'h1)
    |-> (timer_zero_event ##1 !stamp_a_pending) or (!timer_zero_event ##1 stamp_a_pending))
    else $error("Zero moment copy mistimed.");

  AST_SRC_NONE: assert property (@(posedge clk_sys) disable iff (reset)
    (generator_config[`PWOP_T0_SEL] >= 3'h4) |-> !extra_event_zero)
    else $error("Extra event fired with no source.");

  AST_CMP_A: assert property (@(posedge clk_sys) disable iff (reset)
    compare_a_event |-> (timer_step && timer_value == stamp_a_active))
    else $error("Compare A event without a match.");

  AST_ONEOFF_LOW: assert property (@(posedge clk_sys) disable iff (reset)
    (oneoff_a && pwdata[`PWOP_A_ONE] == 2'h1 && hold_active[1:0] != 2'h2) |=> !output_a)
    else $error("One-off low force did not drive A low.");

  AST_TRIG_LEVEL: assert property (@(posedge clk_sys) disable iff (reset)
    (wr_en && paddr == `PWOP_FORCE && pwdata[`PWOP_A_TRIG] == trig_a) |-> !oneoff_a)
    else $error("Unchanged trigger bit fired a force.");

  AST_HOLD_LOW: assert property (@(posedge clk_sys) disable iff (reset)
    (hold_active[1:0] == 2'h1) |=> !output_a)
    else $error("Hold low did not keep A low.");

  AST_CFG_BLOCK: assert property (@(posedge clk_sys) disable iff (reset)
    (generator_config[3] && !wr_act_a) [*2] |-> $stable(act_a_active))
    else $error("Blocked action copy changed actions.");

  AST_UP_HIGH: assert property (@(posedge clk_sys) disable iff (reset)
    (timer_dir_up && events == 6'h04 && act_a_active[5:4] == 2'h2
     && !oneoff_a && hold_active[1:0] inside {2'h0, 2'h3}) |=> output_a)
    else $error("Up-count compare A high action missed.");

endmodule // pwop_top

// ### verif/pwop_top_tb.sv
`timescale 1ns/1ps
`include "pwop_regs.svh"
// Self-checking bench for the operator action logic.
module pwop_top_tb;
  // ----------------------------------------
  // Stimulus and bookkeeping
  // ----------------------------------------
  logic        clk_sys = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd_val;
  logic        pready, pslverr, rd_err, output_a, output_b, dir_up = 1;
  logic [15:0] tval = 0;
  logic [6:0]  ev = 0;    // Bits: zero, period, sync, faults 0..2, step.
  logic [2:0]  rows [5];  // Each row holds an action code and the level it gives.
  int          n_mismatch = 0, comparisons = 0, cyc = 0, exp_b = 0;
  always #12.5 clk_sys = ~clk_sys;
  pwop_top pwop_top_inst (.clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timer_value(tval), .timer_step(ev[6]), .timer_dir_up(dir_up),
    .timer_zero_event(ev[0]), .timer_period_event(ev[1]), .sync_event(ev[2]),
    .fault_event(ev[5:3]), .output_a(output_a), .output_b(output_b));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  // Prints the counts and the verdict, then stops.
  task automatic end_sim;
    $display("comparisons=%0d mismatches=%0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Compares one value and reports a mismatch at once.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One APB transfer; the request is held until pready is seen high.
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk_sys);
    penable <= 1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd_val = prdata;
    rd_err = pslverr;
    psel <= 0; penable <= 0;
    repeat (3) @(posedge clk_sys);  // Lets an immediate copy land.
  endtask
  // Reads a register and checks data and error response.
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic err);
    apb(a, 0, 0);
    chk(rd_val, exp);
    chk({31'h0, rd_err}, {31'h0, err});
  endtask
  // Pulses one event input for a single cycle.
  task automatic pulse(input int i);
    ev <= 7'h01 << i;
    @(posedge clk_sys);
    ev <= 0;
    repeat (2) @(posedge clk_sys);
  endtask
  // Cuts a hang short.
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      end_sim();
    end
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rows = '{3'b101, 3'b001, 3'b110, 3'b111, 3'b010};
    repeat (5) @(posedge clk_sys);
    reset <= 0;
    @(posedge clk_sys);
    chk({output_b, output_a}, 0);
    rd(`PWOP_STAMP_CFG, 0, 0);
    rd(`PWOP_ACT_A, 0, 0);
    // Up-count zero-event actions on output A: high, keep, toggle twice, low.
    foreach (rows[i]) begin
      apb(`PWOP_ACT_A, 1, {30'h0, rows[i][2:1]});
      pulse(0);
      chk(output_a, rows[i][0]);
    end
    // Extra event sources on both outputs while counting down; each source toggles, none leaves the outputs unchanged.
    dir_up <= 0;
    apb(`PWOP_ACT_A, 1, 32'h0030_0000);
    apb(`PWOP_ACT_B, 1, 32'h0030_0000);
    for (int s = 0; s < 5; s++) begin
      apb(`PWOP_GEN_CFG, 1, (s << 4) | 32'h200);
      pulse(s == 3 ? 2 : (s == 4 ? 3 : 3 + s));
      if (s < 4) exp_b = exp_b ^ 1;
      chk(output_b, exp_b);
      chk(output_a, exp_b);
    end
    // Stamp A held in shadow until the zero event, then its pending flag clears.
    dir_up <= 1;
    apb(`PWOP_STAMP_CFG, 1, 32'h1);
    apb(`PWOP_STAMP_A, 1, 32'h5);
    rd(`PWOP_STAMP_CFG, 32'h101, 0);
    pulse(0);
    rd(`PWOP_STAMP_CFG, 32'h1, 0);
    // Stamp B with a blocked moment stays pending across a zero event; then compare A fires on the stamp A copy.
    apb(`PWOP_STAMP_CFG, 1, 32'h81);
    apb(`PWOP_STAMP_B, 1, 32'h7);
    pulse(0);
    rd(`PWOP_STAMP_CFG, 32'h281, 0);
    rd(`PWOP_STAMP_B, 32'h7, 0);
    apb(`PWOP_ACT_A, 1, 32'h20);
    tval <= 16'h5;
    pulse(6);
    chk(output_a, 1);
    // Hold force low overrides a compare action that drives high.
    apb(`PWOP_FORCE, 1, 32'h40);
    chk(output_a, 0);
    pulse(6);
    chk(output_a, 0);
    // One-off force on B fires only when the trigger bit flips.
    apb(`PWOP_FORCE, 1, 32'ha040);
    chk(output_b, 1);
    apb(`PWOP_FORCE, 1, 32'h6040);
    chk(output_b, 1);
    apb(`PWOP_FORCE, 1, 32'h4040);
    chk(output_b, 0);
    // Hold B high and release A, then one-off A high and one-off A low.
    apb(`PWOP_FORCE, 1, 32'h0200);
    chk({output_b, output_a}, 2'b10);
    apb(`PWOP_FORCE, 1, 32'h1600);
    chk({output_b, output_a}, 2'b11);
    apb(`PWOP_FORCE, 1, 32'h0a00);
    chk({output_b, output_a}, 2'b10);
    // An unmapped address answers with an error and zero data.
    rd(8'hd0, 0, 1);
    end_sim();
  end
endmodule // pwop_top_tb
